// >>> psfs_pkg.sv
/*
  psfs_pkg: constants, register map and types for the power sequence and
  fault supervisor. Assumes one 50 MHz clock and 8-bit register data.
*/
`default_nettype none
package psfs_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int NCH = 4;
  localparam int NPIN = 6;
  // start-up, dead-time and overcurrent restart timing
  localparam int STARTUP_MAX_US = 1000;
  localparam int STARTUP_MAX_CYC = STARTUP_MAX_US * (CLK_HZ / 1_000_000);
  localparam int CLEAR_CYC = 4;
  localparam int BUILTIN_NOV_CYC = 2;
  localparam int OC_RESTART_MS = 200;
  localparam int OC_RESTART_CYC = OC_RESTART_MS * (CLK_HZ / 1000);
  localparam int DT_STEPS_PER_PERIOD = 256;
  // writable registers, copied from configuration memory
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_EN_CFG = 5'h01;
  localparam logic [4:0] ADDR_CH_EN_HOST = 5'h02;
  localparam logic [4:0] ADDR_STBY_CFG = 5'h03;
  localparam logic [4:0] ADDR_PIN_DIR = 5'h04;
  localparam logic [4:0] ADDR_PIN_OUT = 5'h05;
  localparam logic [4:0] ADDR_SW_DIV = 5'h06;
  localparam logic [4:0] ADDR_UV_WARN_A = 5'h07;
  localparam logic [4:0] ADDR_UV_FAULT_A = 5'h08;
  localparam logic [4:0] ADDR_UV_WARN_B = 5'h09;
  localparam logic [4:0] ADDR_UV_FAULT_B = 5'h0a;
  localparam logic [4:0] ADDR_THERM_TRIP = 5'h0b;
  localparam logic [4:0] ADDR_THERM_RESTART = 5'h0c;
  localparam logic [4:0] ADDR_TARGET0 = 5'h0d;
  localparam logic [4:0] ADDR_DT_RISE0 = 5'h11;
  localparam logic [4:0] ADDR_DT_FALL0 = 5'h15;
  localparam logic [4:0] ADDR_FOLLOW = 5'h19;
  localparam int NCFG = 26;
  // read-only registers
  localparam logic [4:0] ADDR_VIN_A = 5'h1a;
  localparam logic [4:0] ADDR_VIN_B = 5'h1b;
  localparam logic [4:0] ADDR_TEMP = 5'h1c;
  localparam logic [4:0] ADDR_FLAGS = 5'h1d;
  localparam logic [4:0] ADDR_STATUS = 5'h1e;
  localparam logic [4:0] ADDR_PIN_IN = 5'h1f;
  // control register bits
  localparam int CTRL_PROG_DT = 0;
  localparam int CTRL_UV_AUTO = 1;
  localparam int CTRL_OT_AUTO = 2;
  localparam int CTRL_WARN10 = 3;
  localparam int CTRL_BUS_MODE = 4;
  localparam int CTRL_SOFT_RESTART = 5;
  // standby regulator config bits
  localparam int STBY_5V = 0;
  localparam int STBY_BY_CHIP_EN = 1;
  localparam int STBY_BY_PIN = 2;
  localparam int STBY_BY_HOST = 3;
  localparam int STBY_PIN = 4;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [12:0] TARGET_STEP_MV = 13'h0032;
  localparam logic [6:0] WARN_MARGIN_5K = 7'h01;
  localparam logic [6:0] WARN_MARGIN_10K = 7'h02;

  typedef enum logic [4:0] {
    PSFS_OFF = 5'b00001,
    PSFS_SUPPLY = 5'b00010,
    PSFS_CLEAR = 5'b00100,
    PSFS_COPY = 5'b01000,
    PSFS_READY = 5'b10000
  } psfs_phase_t;

  typedef struct packed {
    logic ot_fault;
    logic ot_warn;
    logic uv_fault;
    logic uv_warn;
    logic [NCH-1:0] ov_fault;
  } psfs_flags_t;
endpackage : psfs_pkg
`default_nettype wire

// >>> psfs_supervisor.sv
/*
  psfs_supervisor: start-up sequencing, register file, channel enables,
  dead-time gate timing and input/thermal/channel protection.
  Assumes configuration memory answers one cycle after its address, and that
  analog measurements and channel trip inputs are already on this clock.
*/
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module psfs_supervisor
  import psfs_pkg::*;
#(
  parameter int OC_RESTART_CYCLES = OC_RESTART_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_enable_pin,
  input wire logic supplies_in_range,
  output logic supply_good_flag,
  output logic internal_clear_pulse_n,
  output logic chip_ready,
  output logic [4:0] nvm_addr,
  input wire logic [7:0] nvm_data,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic bus_ack_enable,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic serial_data_in,
  output logic serial_clk_in,
  input wire logic serial_data_pull_low,
  output logic [2:0] osc_freq_sel,
  output logic standby_regulator_output,
  output logic standby_level_5v,
  input wire logic [7:0] input_a_level,
  input wire logic [7:0] input_b_level,
  input wire logic [6:0] temp_code,
  input wire logic [NCH-1:0] ov_trip,
  input wire logic [NCH-1:0] oc_trip,
  input wire logic [NCH-1:0] pwm_req,
  output logic [NCH-1:0] channel_on,
  output logic [NCH-1:0] gate_high,
  output logic [NCH-1:0] gate_low,
  output logic [NCH*13-1:0] target_mv,
  output logic [7:0] protection_flags
);
  psfs_phase_t phase, next_phase;
  logic [7:0] cfg [0:NCFG-1];
  logic [1:0] en_sync, ok_sync;
  logic [NPIN-1:0] pin_s1, pin_s2;
  logic [2:0] clr_cnt;
  logic [4:0] copy_idx;
  logic copy_wr;
  logic [4:0] copy_waddr;
  logic uv_lock, ot_lock;
  logic [NCH-1:0] ov_latch, oc_hold;
  psfs_flags_t flags;

  // pin inputs and supply status come from outside this clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_sync <= 2'h0;
      ok_sync <= 2'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      en_sync <= {en_sync[0], chip_enable_pin};
      ok_sync <= {ok_sync[0], supplies_in_range};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end
  wire chip_en = en_sync[1];
  wire sup_ok = ok_sync[1];
  wire ready = (phase == PSFS_READY);
  wire [7:0] ctrl = cfg[ADDR_CTRL];
  wire bus_mode = ctrl[CTRL_BUS_MODE];
  wire host_wr = reg_we && ready;
  wire soft_restart = host_wr && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_SOFT_RESTART];
  wire clear_done = (clr_cnt == 3'(CLEAR_CYC - 1));
  wire copy_done = copy_wr && (copy_waddr == 5'(NCFG - 1));

  // phase sequencing
  always_comb begin
    next_phase = phase;
    unique case (phase)
      PSFS_OFF: if (chip_en) next_phase = PSFS_SUPPLY;
      PSFS_SUPPLY: if (sup_ok) next_phase = PSFS_CLEAR;
      PSFS_CLEAR: if (clear_done) next_phase = PSFS_COPY;
      PSFS_COPY: if (copy_done) next_phase = PSFS_READY;
      PSFS_READY: if (soft_restart) next_phase = PSFS_CLEAR;
    endcase
    if (!chip_en) next_phase = PSFS_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PSFS_OFF;
      clr_cnt <= 3'h0;
      copy_idx <= 5'h0;
      copy_wr <= 1'b0;
      copy_waddr <= 5'h0;
    end else begin
      phase <= next_phase;
      clr_cnt <= (phase == PSFS_CLEAR) ? clr_cnt + 3'h1 : 3'h0;
      copy_wr <= (phase == PSFS_COPY) && (copy_idx < 5'(NCFG)) && !copy_done;
      copy_waddr <= copy_idx;
      copy_idx <= (phase == PSFS_COPY) && (copy_idx < 5'(NCFG)) ? copy_idx + 5'h1 : 5'h0;
    end
  end
  assign nvm_addr = copy_idx;
  assign supply_good_flag = sup_ok && chip_en && (phase != PSFS_OFF);
  assign internal_clear_pulse_n = (phase != PSFS_CLEAR);
  assign chip_ready = ready;
  assign bus_ack_enable = ready;

  // register file: cleared by the clear pulse, loaded by copy, then host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCFG; i++) cfg[i] <= CFG_RESET;
    end else if (phase == PSFS_CLEAR) begin
      for (int i = 0; i < NCFG; i++) cfg[i] <= CFG_RESET;
    end else if (copy_wr) begin
      cfg[copy_waddr] <= nvm_data;
    end else if (host_wr && (reg_addr < 5'(NCFG))) begin
      cfg[reg_addr] <= (reg_addr == ADDR_CTRL) ? (reg_wdata & ~8'h20) : reg_wdata;
    end
  end
  assign osc_freq_sel = cfg[ADDR_SW_DIV][6:4];

  // pins: directions from configuration, four and five lent to the bus
  wire [NPIN-1:0] bus_pins = bus_mode ? 6'h30 : 6'h00;
  assign pin_oe = ready ? ((cfg[ADDR_PIN_DIR][5:0] & ~bus_pins) |
                  {1'b0, bus_mode & serial_data_pull_low, 4'h0}) : 6'h00;
  // data pin is open drain in bus mode: enable only, level held low
  assign pin_out = cfg[ADDR_PIN_OUT][5:0] & ~bus_pins;
  assign serial_data_in = bus_mode & pin_s2[4];
  assign serial_clk_in = bus_mode & pin_s2[5];
  wire [NPIN-1:0] gp_in = pin_s2 & ~bus_pins;

  // standby regulator
  wire [7:0] stby = cfg[ADDR_STBY_CFG];
  assign standby_level_5v = stby[STBY_5V];
  assign standby_regulator_output = (stby[STBY_BY_CHIP_EN] & chip_en) |
      (stby[STBY_BY_PIN] & gp_in[STBY_PIN]) | (stby[STBY_BY_HOST] & ready);

  // input undervoltage, one lockout for both inputs
  wire uv_warn_now = (input_a_level < cfg[ADDR_UV_WARN_A]) ||
                     (input_b_level < cfg[ADDR_UV_WARN_B]);
  wire uv_fault_now = (input_a_level < cfg[ADDR_UV_FAULT_A]) ||
                      (input_b_level < cfg[ADDR_UV_FAULT_B]);
  // thermal, codes in 5K steps from 200K
  wire [6:0] warn_margin = ctrl[CTRL_WARN10] ? WARN_MARGIN_10K : WARN_MARGIN_5K;
  wire [6:0] trip = cfg[ADDR_THERM_TRIP][6:0];
  wire ot_fault_now = (temp_code >= trip);
  wire ot_warn_now = ({1'b0, temp_code} + {1'b0, warn_margin} >= {1'b0, trip});
  wire ot_cool = (temp_code < cfg[ADDR_THERM_RESTART][6:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uv_lock <= 1'b0;
      ot_lock <= 1'b0;
      flags <= '0;
    end else if (!ready) begin
      uv_lock <= 1'b0;
      ot_lock <= 1'b0;
      flags <= '0;
    end else begin
      if (uv_fault_now) uv_lock <= 1'b1;
      else if (ctrl[CTRL_UV_AUTO] && !uv_warn_now) uv_lock <= 1'b0;
      if (ot_fault_now) ot_lock <= 1'b1;
      else if (ctrl[CTRL_OT_AUTO] && ot_cool) ot_lock <= 1'b0;
      flags.uv_warn <= uv_warn_now;
      flags.uv_fault <= uv_fault_now | (uv_lock & ~(ctrl[CTRL_UV_AUTO] & ~uv_warn_now));
      flags.ot_warn <= ot_warn_now | ot_fault_now;
      flags.ot_fault <= ot_fault_now | (ot_lock & ~(ctrl[CTRL_OT_AUTO] & ot_cool));
      flags.ov_fault <= ov_latch;
    end
  end
  assign protection_flags = flags;

  // channel enables
  wire [3:0] always_on = cfg[ADDR_EN_CFG][3:0];
  wire [3:0] pin_ctl = cfg[ADDR_EN_CFG][7:4];
  wire [3:0] host_en = cfg[ADDR_CH_EN_HOST][3:0];
  wire [3:0] requested = always_on | (pin_ctl & gp_in[3:0]) | host_en;
  wire host_reenable = host_wr && (reg_addr == ADDR_CH_EN_HOST);
  wire ov_any = |(ov_trip & channel_on);
  assign channel_on = ready && !uv_lock && !ot_lock ?
                      (requested & ~ov_latch & ~oc_hold) : 4'h0;

  // dead-time step: switching period is 256 steps of (divider + 1) clocks
  logic [7:0] step_cnt;
  wire dt_tick = (step_cnt == 8'h00);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) step_cnt <= 8'h00;
    else step_cnt <= dt_tick ? {5'h00, cfg[ADDR_SW_DIV][2:0]} : step_cnt - 8'h01;
  end
  wire prog_dt = ctrl[CTRL_PROG_DT];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [7:0] dt_cnt;
    logic [27:0] oc_cnt;
    wire dt_busy = (dt_cnt != 8'h00);
    wire dt_dec = prog_dt ? dt_tick : 1'b1;
    wire [7:0] rise_load = prog_dt ? cfg[ADDR_DT_RISE0 + 5'(c)] : 8'(BUILTIN_NOV_CYC);
    wire [7:0] fall_load = prog_dt ? cfg[ADDR_DT_FALL0 + 5'(c)] : 8'(BUILTIN_NOV_CYC);
    wire ov_here = ov_trip[c] & channel_on[c];
    wire follows = cfg[ADDR_FOLLOW][c];
    assign target_mv[c*13 +: 13] = 13'(cfg[ADDR_TARGET0 + 5'(c)]) * TARGET_STEP_MV;

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ov_latch[c] <= 1'b0;
        oc_hold[c] <= 1'b0;
        oc_cnt <= 28'h0;
      end else begin
        // a new trip in the re-enable cycle wins
        if (ov_here || (follows && ov_any)) ov_latch[c] <= 1'b1;
        else if (!ready || (host_reenable && reg_wdata[c])) ov_latch[c] <= 1'b0;
        if (oc_trip[c] && channel_on[c]) begin
          oc_hold[c] <= 1'b1;
          oc_cnt <= 28'(OC_RESTART_CYCLES - 1);
        end else if (!ready) begin
          oc_hold[c] <= 1'b0;
        end else if (oc_hold[c]) begin
          if (oc_cnt == 28'h0) oc_hold[c] <= 1'b0;
          else oc_cnt <= oc_cnt - 28'h1;
        end
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        gate_high[c] <= 1'b0;
        gate_low[c] <= 1'b0;
        dt_cnt <= 8'h00;
      end else if (!channel_on[c]) begin
        gate_high[c] <= 1'b0;
        gate_low[c] <= 1'b0;
        dt_cnt <= 8'h00;
      end else if (pwm_req[c]) begin
        if (gate_low[c]) begin
          gate_low[c] <= 1'b0;
          dt_cnt <= rise_load;
        end else if (dt_busy) begin
          if (dt_dec) dt_cnt <= dt_cnt - 8'h01;
          // last count turns the gate on, so the gap equals the setting
          if (dt_dec && dt_cnt == 8'h01) gate_high[c] <= 1'b1;
        end else begin
          gate_high[c] <= 1'b1;
        end
      end else begin
        if (gate_high[c]) begin
          gate_high[c] <= 1'b0;
          dt_cnt <= fall_load;
        end else if (dt_busy) begin
          if (dt_dec) dt_cnt <= dt_cnt - 8'h01;
          if (dt_dec && dt_cnt == 8'h01) gate_low[c] <= 1'b1;
        end else begin
          gate_low[c] <= 1'b1;
        end
      end
    end

    no_overlap_a: assert property (@(posedge clk) disable iff (rst)
      !(gate_high[c] && gate_low[c])) else $error("both gates on");
    ov_holds_a: assert property (@(posedge clk) disable iff (rst)
      ov_here |=> !channel_on[c]) else $error("channel on after overvoltage");
    // 50 as 32 + 16 + 2, independent of the multiplier above
    target_scale_a: assert property (@(posedge clk) disable iff (rst)
      target_mv[c*13 +: 13] == (13'(cfg[ADDR_TARGET0 + 5'(c)]) << 5) +
        (13'(cfg[ADDR_TARGET0 + 5'(c)]) << 4) + (13'(cfg[ADDR_TARGET0 + 5'(c)]) << 1))
      else $error("target not code times 50mV");
  end

  // register reads, one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr < 5'(NCFG)) rd_mux = cfg[reg_addr];
    unique case (reg_addr)
      ADDR_VIN_A: rd_mux = input_a_level;
      ADDR_VIN_B: rd_mux = input_b_level;
      ADDR_TEMP: rd_mux = {1'b0, temp_code};
      ADDR_FLAGS: rd_mux = flags;
      ADDR_STATUS: rd_mux = {channel_on, 1'b0, uv_lock, ot_lock, ready};
      ADDR_PIN_IN: rd_mux = {2'b00, gp_in};
      default: ;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) reg_rdata <= 8'h00;
    else reg_rdata <= reg_re ? rd_mux : 8'h00;
  end

  // helper: cycles from leaving supply bring-up to ready
  logic [15:0] boot_cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) boot_cnt <= 16'h0;
    else if (phase == PSFS_CLEAR || phase == PSFS_COPY) boot_cnt <= boot_cnt + 16'h1;
    else boot_cnt <= 16'h0;
  end

  boot_time_a: assert property (@(posedge clk) disable iff (rst)
    boot_cnt < 16'(STARTUP_MAX_CYC)) else $error("start-up too long");
  clear_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(phase == PSFS_CLEAR) |-> !internal_clear_pulse_n [*4] ##1 (phase != PSFS_CLEAR))
    else $error("clear pulse length wrong");
  no_ack_early_a: assert property (@(posedge clk) disable iff (rst)
    !ready |-> !bus_ack_enable) else $error("ack before ready");
  idle_before_ready_a: assert property (@(posedge clk) disable iff (rst)
    !ready |-> (channel_on == 4'h0) && (flags == '0)) else $error("active before ready");
  uv_shutdown_a: assert property (@(posedge clk) disable iff (rst)
    ready && uv_fault_now |=> (channel_on == 4'h0) && flags.uv_fault)
    else $error("undervoltage did not stop channels");
  ot_shutdown_a: assert property (@(posedge clk) disable iff (rst)
    ready && ot_fault_now |=> flags.ot_warn && flags.ot_fault && (channel_on == 4'h0))
    else $error("thermal fault not handled");
  enable_off_a: assert property (@(posedge clk) disable iff (rst)
    !chip_en |=> (phase == PSFS_OFF)) else $error("runs without chip enable");
  stby_level_a: assert property (@(posedge clk) disable iff (rst)
    stby[STBY_BY_CHIP_EN] && chip_en |-> standby_regulator_output &&
      (standby_level_5v == stby[STBY_5V])) else $error("standby regulator wrong");
endmodule : psfs_supervisor
`default_nettype wire

// >>> psfs_nvm_model.sv
/*
  psfs_nvm_model: configuration memory read by the supervisor's copy phase.
  Assumes one read per cycle on the supervisor clock, data one cycle after address.
*/
`timescale 1ns/1ps
`default_nettype none
module psfs_nvm_model
  import psfs_pkg::*;
#(
  parameter logic [NCFG*8-1:0] IMAGE = '0
) (
  input wire logic clk,
  input wire logic [4:0] addr,
  output logic [7:0] data
);
  // nothing stored past the image: a toggling byte keeps stale data from passing as valid
  always_ff @(posedge clk) begin
    if (int'(addr) < NCFG) begin
      data <= IMAGE[addr*8+:8];
    end else begin
      data <= ~data;
    end
  end
endmodule : psfs_nvm_model
`default_nettype wire

// >>> testbench.sv
/*
  testbench: start-up, register access, channel enables, protection and gate timing
  of the supervisor. Assumes the memory model above, a 50 MHz clock and a
  restart delay shortened to 50 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import psfs_pkg::*;
  localparam int OCN = 50;
  localparam logic [NCFG*8-1:0] IMG = {8'h00, {4{8'h03}}, {4{8'h05}}, 8'h66, 8'h34, 8'h32, 8'h12,
    8'h3c, 8'h40, 8'h2a, 8'h30, 8'h2a, 8'h30, 8'h30, 8'h00, 8'h00, 8'h03, 8'h00, 8'h21, 8'h00};
  logic clk, rst, chip_en, sup_ok, sgood, clr_n, ready, re, we, ack, sdi, sci, pull, stby_on, stby5;
  logic [4:0] nvm_a, addr;
  logic [7:0] nvm_d, wdata, rdata, lvl_a, lvl_b, flags;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe;
  logic [2:0] osc;
  logic [6:0] temp;
  logic [NCH-1:0] ov, oc, pwm, ch_on, gh, gl;
  logic [NCH*13-1:0] tmv;
  int n_mismatch, checks;

  psfs_supervisor #(.OC_RESTART_CYCLES(OCN)) psfs_supervisor_i (.clk(clk), .rst(rst),
    .chip_enable_pin(chip_en), .supplies_in_range(sup_ok), .supply_good_flag(sgood),
    .internal_clear_pulse_n(clr_n), .chip_ready(ready), .nvm_addr(nvm_a), .nvm_data(nvm_d),
    .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata),
    .bus_ack_enable(ack), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .serial_data_in(sdi), .serial_clk_in(sci), .serial_data_pull_low(pull), .osc_freq_sel(osc),
    .standby_regulator_output(stby_on), .standby_level_5v(stby5), .input_a_level(lvl_a),
    .input_b_level(lvl_b), .temp_code(temp), .ov_trip(ov), .oc_trip(oc), .pwm_req(pwm),
    .channel_on(ch_on), .gate_high(gh), .gate_low(gl), .target_mv(tmv), .protection_flags(flags));
  psfs_nvm_model #(.IMAGE(IMG)) psfs_nvm_model_i (.clk(clk), .addr(nvm_a), .data(nvm_d));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic stuck(input string what);
    n_mismatch++;
    $display("MISMATCH %s exp done got timeout", what);
    final_report();
  endtask : stuck

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    `CHK($sformatf("reg %0h", a), e, rdata)
  endtask : rchk

  task automatic wait_ready(output int n);
    for (n = 0; ready !== 1'b1; n++) begin
      if (n > STARTUP_MAX_CYC) stuck("ready");
      cyc(1);
    end
  endtask : wait_ready

  task automatic trip(input logic [3:0] ovm, input logic [3:0] ocm);
    @(posedge clk);
    ov <= ovm;
    oc <= ocm;
    @(posedge clk);
    ov <= 4'h0;
    oc <= 4'h0;
    cyc(3);
  endtask : trip

  // cycles from the off gate dropping to the on gate rising, channel 0
  task automatic gap(input logic up, input int e);
    int n;
    @(posedge clk);
    pwm <= {3'b000, up};
    for (n = 0; (up ? gl[0] : gh[0]) !== 1'b0; n++) begin
      if (n > 50) stuck("gate off");
      cyc(1);
    end
    for (n = 0; (up ? gh[0] : gl[0]) !== 1'b1; n++) begin
      if (n > 300) stuck("gate on");
      cyc(1);
    end
    `CHK("dead time", e, n)
  endtask : gap

  task automatic temp_to(input logic [6:0] t);
    @(posedge clk);
    temp <= t;
    cyc(4);
  endtask : temp_to

  initial begin
    int n;
    rst = 1'b1;
    chip_en = 1'b0;
    sup_ok = 1'b1;
    {addr, wdata, we, re, pull, ov, oc, pwm} = '0;
    pin_in = 6'h02;
    lvl_a = 8'h50;
    lvl_b = 8'h50;
    temp = 7'h20;
    n_mismatch = 0;
    checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(ADDR_FOLLOW, 8'hff);
    chip_en <= 1'b1;
    for (n = 0; clr_n !== 1'b0; n++) begin
      if (n > 100) stuck("clear");
      cyc(1);
    end
    `CHK("supply good", 1'b1, sgood)
    `CHK("early channels", 4'h0, ch_on)
    `CHK("early ack", 1'b0, ack)
    for (n = 0; clr_n === 1'b0 && n < 100; n++) cyc(1);
    `CHK("clear length", CLEAR_CYC, n)
    wait_ready(n);
    `CHK("startup time", 1'b1, n < STARTUP_MAX_CYC)
    `CHK("ack at ready", 1'b1, ack)
    $display("test startup done");
    // early write to the follow mask must have been dropped
    for (int i = 0; i < NCFG; i++) rchk(5'(i), IMG[i*8+:8]);
    `CHK("osc select", 3'h3, osc)
    `CHK("pin dir", 6'h00, pin_oe)
    `CHK("ready channels", 4'b0011, ch_on)
    for (int c = 0; c < NCH; c++) `CHK("target", 13'(IMG[(13+c)*8+:8]) * 13'd50, tmv[c*13+:13])
    `CHK("stby on", 1'b1, stby_on)
    `CHK("stby 5v", 1'b1, stby5)
    @(posedge clk);
    pin_in <= 6'h00;
    cyc(4);
    `CHK("pin enable", 4'b0001, ch_on)
    wr(ADDR_CH_EN_HOST, 8'h08);
    cyc(2);
    `CHK("host enable", 4'b1001, ch_on)
    wr(ADDR_CH_EN_HOST, 8'h00);
    pin_in <= 6'h02;
    wr(ADDR_STBY_CFG, 8'h08);
    cyc(2);
    `CHK("stby host", 2'b10, {stby_on, stby5})
    wr(ADDR_STBY_CFG, 8'h00);
    cyc(2);
    `CHK("stby off", 1'b0, stby_on)
    wr(ADDR_TEMP, 8'hff);
    rchk(ADDR_TEMP, 8'h20);
    $display("test enables done");
    wr(ADDR_CTRL, 8'h0e);
    @(posedge clk);
    lvl_a <= 8'h2f;
    cyc(4);
    `CHK("uv warn", 8'h10, flags)
    rchk(ADDR_VIN_A, 8'h2f);
    @(posedge clk);
    lvl_b <= 8'h29;
    cyc(4);
    `CHK("uv fault", 8'h30, flags)
    `CHK("uv off", 4'h0, ch_on)
    rchk(ADDR_VIN_B, 8'h29);
    @(posedge clk);
    lvl_a <= 8'h50;
    lvl_b <= 8'h50;
    cyc(4);
    `CHK("uv restart", 4'b0011, ch_on)
    $display("test undervoltage done");
    temp_to(7'h3d);
    `CHK("no warn", 2'b00, flags[7:6])
    temp_to(7'h3e);
    `CHK("warn 10", 2'b01, flags[7:6])
    temp_to(7'h40);
    `CHK("ot fault", 2'b11, flags[7:6])
    `CHK("ot off", 4'h0, ch_on)
    rchk(ADDR_TEMP, 8'h40);
    temp_to(7'h3b);
    `CHK("ot restart", 4'b0011, ch_on)
    wr(ADDR_CTRL, 8'h06);
    temp_to(7'h3e);
    `CHK("no warn 5", 2'b00, flags[7:6])
    temp_to(7'h3f);
    `CHK("warn 5", 2'b01, flags[7:6])
    temp_to(7'h20);
    $display("test thermal done");
    trip(4'h0, 4'h1);
    `CHK("oc off", 1'b0, ch_on[0])
    cyc(OCN - 8);
    `CHK("oc hold", 1'b0, ch_on[0])
    cyc(12);
    `CHK("oc restart", 1'b1, ch_on[0])
    wr(ADDR_FOLLOW, 8'h02);
    wr(ADDR_CH_EN_HOST, 8'h04);
    cyc(2);
    `CHK("ch2 on", 4'b0111, ch_on)
    trip(4'h4, 4'h0);
    `CHK("ov off", 4'b0001, ch_on)
    // the follower's shutdown latch reports in its own fault bit
    `CHK("ov flag", 4'b0110, flags[3:0])
    cyc(OCN + 10);
    `CHK("ov stays off", 4'b0001, ch_on)
    wr(ADDR_CH_EN_HOST, 8'h06);
    cyc(2);
    `CHK("ov re-enable", 4'b0111, ch_on)
    $display("test channel faults done");
    gap(1'b1, BUILTIN_NOV_CYC);
    gap(1'b0, BUILTIN_NOV_CYC);
    wr(ADDR_CTRL, 8'h07);
    gap(1'b1, 5);
    gap(1'b0, 3);
    $display("test dead time done");
    @(posedge clk);
    pin_in <= 6'h22;
    cyc(4);
    `CHK("no bus clk", 1'b0, sci)
    wr(ADDR_CTRL, 8'h16);
    // link clock at 160 ns, running only inside this frame
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      pin_in[5] <= ~pin_in[5];
      cyc(3);
      `CHK("bus clk", pin_in[5], sci)
    end
    @(posedge clk);
    pin_in[4] <= 1'b1;
    cyc(3);
    `CHK("bus data", 1'b1, sdi)
    @(posedge clk);
    pull <= 1'b1;
    cyc(3);
    `CHK("sda drive", 2'b10, {pin_oe[4], pin_out[4]})
    @(posedge clk);
    pull <= 1'b0;
    $display("test bus mode done");
    wr(ADDR_CH_EN_HOST, 8'h0f);
    wr(ADDR_CTRL, 8'h20);
    cyc(2);
    `CHK("soft restart", 1'b0, ready)
    wait_ready(n);
    rchk(ADDR_CH_EN_HOST, 8'h00);
    rchk(ADDR_CTRL, 8'h00);
    @(posedge clk);
    chip_en <= 1'b0;
    cyc(5);
    `CHK("chip off", 6'h00, {ready, sgood, ch_on})
    $display("test reset done");
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk);
    stuck("run");
  end
endmodule : testbench
`default_nettype wire
